//--- core/swfd_pkg.sv
// Constants, field layouts and types of the serial word format decoder
// How it works
// R1 - Host sends reset word with key
// R2 - Matching key returns all state to defaults
// R3 - Bit 15 set writes code to DAC channel
// R4 - ADC word: bit15 zero, channel, result
// R5 - Temperature word: tag 1000, then result
// R6 - DAC readback word has bit 15 set
// R7 - Readback carries channel in bits 14:12
// R8 - Readback data is DAC input register
// R9 - Host classifies returned words by top bits
package swfd_pkg;
   // ==========================================================
   // Word layout
   localparam int WORD_W      = 16;
   localparam int CH_W        = 3;
   localparam int DATA_W      = 12;
   localparam int NUM_CH      = 8;
   localparam int BIT_MSB     = 15;
   localparam int CH_HI       = 14;
   localparam int CH_LO       = 12;
   localparam int DATA_HI     = 11;
   localparam int ADDR_HI     = 14;
   localparam int ADDR_LO     = 11;
   localparam int KEY_HI      = 10;
   localparam int TAG_W       = 4;
   localparam int CNT_W       = 5;

   // ==========================================================
   // Codes
   localparam logic [3:0]        RESET_ADDR           = 4'hF;
   localparam logic [10:0]       SOFTWARE_RESET_KEY   = 11'h5AC;
   localparam logic [TAG_W-1:0]  TEMPERATURE_TAG      = 4'h8;
   localparam logic              MSB_DAC              = 1'h1;
   localparam logic              MSB_ADC              = 1'h0;
   localparam logic [CNT_W-1:0]  BITS_PER_WORD        = 5'h10;
   localparam logic [DATA_W-1:0] DAC_RESET_CODE       = 12'h000;
   localparam logic [WORD_W-1:0] IDLE_WORD            = 16'h0000;

   // ==========================================================
   // Pin indices and idle levels (clock idles high)
   localparam int         PIN_SCLK = 0;
   localparam int         PIN_CS   = 1;
   localparam int         PIN_DIN  = 2;
   localparam logic [2:0] PIN_IDLE = 3'h3;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SWFD_KIND_ADC  = 2'h0,
      SWFD_KIND_TEMP = 2'h1,
      SWFD_KIND_DAC  = 2'h2
   } swfd_kind_t;

   typedef enum logic [2:0] {
      SWFD_ST_IDLE  = 3'b001,
      SWFD_ST_FETCH = 3'b010,
      SWFD_ST_HOLD  = 3'b100
   } swfd_state_t;

   // Channel result word: tag bit, channel, 12-bit data
   function automatic logic [WORD_W-1:0] swfd_chan_word(
      input logic              msb,
      input logic [CH_W-1:0]   ch,
      input logic [DATA_W-1:0] data
   );
      swfd_chan_word = {msb, ch, data};
   endfunction
endpackage

//--- core/swfd_dac_mem.sv
// Eight-entry DAC input register store with registered read
`timescale 1ns/100ps
module swfd_dac_mem #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   // Clock and control
   input  wire logic             ref_clk,
   input  wire logic             ce,
   input  wire logic             clear,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read port
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (clear) begin
            for (int i = 0; i < DEPTH; i++) begin
               mem_q[i] <= '0;
            end
         end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (clear) begin
            rd_data <= '0;
         end else begin
            rd_data <= mem_q[rd_addr];
         end
      end
   end
endmodule // swfd_dac_mem

//--- core/swfd_core.sv
// Serial word decoder and result word builder on the serial link
`timescale 1ns/100ps
module swfd_core
   import swfd_pkg::*;
(
   // Clock, enable and reset
   input  wire logic                        ref_clk,
   input  wire logic                        ce,
   input  wire logic                        reset,
   // Serial pins
   input  wire logic                        sclk,
   input  wire logic                        sync_n,
   input  wire logic                        din,
   output logic                             dout,
   // Result request from converter side
   input  wire logic                        resp_valid,
   input  wire swfd_pkg::swfd_kind_t        resp_kind,
   input  wire logic [swfd_pkg::CH_W-1:0]   resp_channel,
   input  wire logic [swfd_pkg::DATA_W-1:0] resp_data,
   output logic                             resp_ready,
   // DAC load output
   output logic                             dac_load,
   output logic [swfd_pkg::CH_W-1:0]        dac_channel,
   output logic [swfd_pkg::DATA_W-1:0]      dac_code,
   // Software reset indication
   output logic                             soft_reset
);
   import swfd_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [2:0]        s1_q;
   logic [2:0]        s2_q;
   logic [2:0]        s3_q;
   logic [2:0]        pin_q;
   logic [2:0]        pin_d;
   logic [2:0]        pin_prev_q;
   logic              clear_all;
   logic              soft_q;

   assign clear_all = reset | soft_q; // R2

   always_comb begin
      pin_d = pin_q;
      for (int i = 0; i < $bits(pin_q); i++) begin
         if (s2_q[i] == s3_q[i]) begin
            pin_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s1_q       <= PIN_IDLE;
         s2_q       <= PIN_IDLE;
         s3_q       <= PIN_IDLE;
         pin_q      <= PIN_IDLE;
         pin_prev_q <= PIN_IDLE;
      end else if (ce) begin
         s1_q       <= {din, sync_n, sclk};
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         pin_q      <= pin_d;
         pin_prev_q <= pin_q;
      end
   end

   logic cs_active;
   logic frame_start;
   logic sclk_fall;
   logic sclk_rise;

   assign cs_active   = ~pin_q[PIN_CS];
   assign frame_start = pin_prev_q[PIN_CS] & ~pin_q[PIN_CS];
   assign sclk_fall   = cs_active & pin_prev_q[PIN_SCLK] & ~pin_q[PIN_SCLK];
   assign sclk_rise   = cs_active & ~pin_prev_q[PIN_SCLK] & pin_q[PIN_SCLK];

   // ==========================================================
   // Receive shifter, sampled on falling clock edges
   logic [WORD_W-1:0] rx_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [WORD_W-1:0] rx_word;
   logic              word_done;

   assign rx_word   = {rx_q[WORD_W-2:0], pin_q[PIN_DIN]};
   assign word_done = sclk_fall && (cnt_q == BITS_PER_WORD - 5'h01);

   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         rx_q  <= IDLE_WORD;
         cnt_q <= '0;
      end else if (ce) begin
         if (!cs_active) begin
            cnt_q <= '0;
         end else if (sclk_fall) begin
            rx_q  <= rx_word;
            cnt_q <= word_done ? '0 : cnt_q + 5'h01;
         end
      end
   end

   // ==========================================================
   // Decode of a complete received word
   logic is_dac_wr;
   logic is_reset;

   assign is_dac_wr = word_done && (rx_word[BIT_MSB] == MSB_DAC); // R3
   assign is_reset  = word_done && (rx_word[BIT_MSB] == MSB_ADC)
                      && (rx_word[ADDR_HI:ADDR_LO] == RESET_ADDR)
                      && (rx_word[KEY_HI:0] == SOFTWARE_RESET_KEY); // R1 R2

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         soft_q     <= 1'b0;
         soft_reset <= 1'b0;
      end else if (ce) begin
         soft_q     <= is_reset; // R2
         soft_reset <= is_reset;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         dac_load    <= 1'b0;
         dac_channel <= '0;
         dac_code    <= DAC_RESET_CODE;
      end else if (ce) begin
         dac_load <= is_dac_wr;
         if (is_dac_wr) begin
            dac_channel <= rx_word[CH_HI:CH_LO]; // R3
            dac_code    <= rx_word[DATA_HI:0]; // R3
         end
      end
   end

   // ==========================================================
   // DAC input register store
   logic [CH_W-1:0]   rd_ch_q;
   logic [CH_W-1:0]   rd_addr;
   logic [DATA_W-1:0] rd_data;

   swfd_dac_mem #(
      .WIDTH (DATA_W),
      .DEPTH (NUM_CH),
      .AW    (CH_W)
   ) u_mem (
      .ref_clk (ref_clk),
      .ce      (ce),
      .clear   (clear_all),
      .wr_en   (is_dac_wr),
      .wr_addr (rx_word[CH_HI:CH_LO]),
      .wr_data (rx_word[DATA_HI:0]),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // ==========================================================
   // Result word builder
   swfd_state_t       st_q;
   swfd_state_t       st_d;
   logic [WORD_W-1:0] tx_word_q;
   logic [WORD_W-1:0] tx_word_d;
   logic              take;

   assign take = resp_valid & resp_ready;

   // Read the store at the take, so the fetch cycle sees the new channel
   assign rd_addr = take ? resp_channel : rd_ch_q; // R7 R8

   always_comb begin
      st_d      = st_q;
      tx_word_d = tx_word_q;
      unique case (st_q)
         SWFD_ST_IDLE: begin
            if (take) begin
               unique case (resp_kind)
                  SWFD_KIND_ADC: begin
                     tx_word_d = swfd_chan_word(MSB_ADC, resp_channel, resp_data); // R4
                     st_d      = SWFD_ST_HOLD;
                  end
                  SWFD_KIND_TEMP: begin
                     tx_word_d = {TEMPERATURE_TAG, resp_data}; // R5
                     st_d      = SWFD_ST_HOLD;
                  end
                  default: begin
                     st_d = SWFD_ST_FETCH;
                  end
               endcase
            end
         end
         SWFD_ST_FETCH: begin
            tx_word_d = swfd_chan_word(MSB_DAC, rd_ch_q, rd_data); // R6 R7 R8
            st_d      = SWFD_ST_HOLD;
         end
         SWFD_ST_HOLD: begin
            if (frame_start) begin
               st_d = SWFD_ST_IDLE;
            end
         end
         default: begin
            st_d = SWFD_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         st_q       <= SWFD_ST_IDLE;
         tx_word_q  <= IDLE_WORD;
         rd_ch_q    <= '0;
         resp_ready <= 1'b0;
      end else if (ce) begin
         st_q       <= st_d;
         tx_word_q  <= tx_word_d;
         resp_ready <= (st_d == SWFD_ST_IDLE);
         if (take) begin
            rd_ch_q <= resp_channel; // R7
         end
      end
   end

   // ==========================================================
   // Transmit shifter, advanced on rising clock edges
   logic [WORD_W-1:0] tx_sh_q;
   logic [WORD_W-1:0] load_word;

   // An unloaded frame returns zeros
   assign load_word = (st_q == SWFD_ST_HOLD) ? tx_word_q : IDLE_WORD;

   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         tx_sh_q <= IDLE_WORD;
         dout    <= 1'b0;
      end else if (ce) begin
         if (frame_start) begin
            tx_sh_q <= {load_word[WORD_W-2:0], 1'b0};
            dout    <= load_word[BIT_MSB];
         end else if (sclk_rise) begin
            tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
            dout    <= tx_sh_q[BIT_MSB];
         end
      end
   end
endmodule // swfd_core

//--- sim/swfd_core_properties.sv
// Port assertions for the serial word decoder
`timescale 1ns/100ps
module swfd_core_properties
   import swfd_pkg::*;
(
   // Watched ports
   input wire logic                        ref_clk,
   input wire logic                        reset,
   input wire logic                        sclk,
   input wire logic                        sync_n,
   input wire logic                        resp_valid,
   input wire logic                        resp_ready,
   input wire logic                        dac_load,
   input wire logic [swfd_pkg::CH_W-1:0]   dac_channel,
   input wire logic [swfd_pkg::DATA_W-1:0] dac_code,
   input wire logic                        soft_reset
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // Sequences
   sequence s_take;
      resp_valid && resp_ready;
   endsequence
   // A word ends inside a frame just after a serial clock fall
   sequence s_word_end;
      !$past(sync_n, 4) && !$past(sclk, 2);
   endsequence
   // ==========================================================
   // Properties
   property p_load_pulse; dac_load |=> !dac_load; endproperty
   property p_rst_pulse;
      soft_reset |=> !soft_reset && dac_code == 12'h000 && dac_channel == 3'h0;
   endproperty
   property p_excl; !(dac_load && soft_reset); endproperty
   property p_hold;
      !dac_load && !$past(soft_reset) |-> $stable(dac_code) && $stable(dac_channel);
   endproperty
   property p_load_frame; dac_load |-> s_word_end; endproperty
   property p_rst_frame; soft_reset |-> s_word_end; endproperty
   property p_take; s_take |=> !resp_ready; endproperty
   property p_hw_reset;
      disable iff (1'b0) reset |=> !dac_load && !soft_reset && !resp_ready && dac_code == 12'h000;
   endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
   a_rst_pulse: assert property (p_rst_pulse) else $error("soft reset did not clear");
   a_excl: assert property (p_excl) else $error("load and soft reset together");
   a_hold: assert property (p_hold) else $error("dac outputs moved without load");
   a_load_frame: assert property (p_load_frame) else $error("load outside a word");
   a_rst_frame: assert property (p_rst_frame) else $error("soft reset outside a word");
   a_take: assert property (p_take) else $error("ready stayed high after take");
   a_hw_reset: assert property (p_hw_reset) else $error("reset left outputs set");
endmodule // swfd_core_properties

bind swfd_core swfd_core_properties u_props (.ref_clk(ref_clk), .reset(reset), .sclk(sclk),
   .sync_n(sync_n), .resp_valid(resp_valid), .resp_ready(resp_ready), .dac_load(dac_load),
   .dac_channel(dac_channel), .dac_code(dac_code), .soft_reset(soft_reset));

//--- sim/swfd_host_model.sv
// Serial host model that clocks one word in and out per frame
`timescale 1ns/100ps
module swfd_host_model (
   // Clock and control
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        go,
   input  wire logic        slow,
   input  wire logic [15:0] tx_word,
   // Serial pins
   output logic             sclk,
   output logic             sync_n,
   output logic             din,
   input  wire logic        dout,
   // Status
   output logic             busy,
   output logic [15:0]      rx_word
);
   logic [15:0] sh_q;
   logic [2:0]  cnt_q;
   logic [5:0]  ph_q;
   // Eight ref_clk cycles per half period, MSB first
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync_n <= 1'h1;
         sclk <= 1'h1;
         din <= 1'h0;
         busy <= 1'h0;
      end else if (!busy) begin
         if (go) begin
            busy <= 1'h1;
            sync_n <= 1'h0;
            sh_q <= tx_word;
            din <= tx_word[15];
            cnt_q <= 3'h0;
            ph_q <= 6'h00;
         end
      end else if (cnt_q != 3'h7) begin
         cnt_q <= cnt_q + 3'h1;
      end else begin
         cnt_q <= 3'h0;
         ph_q <= ph_q + 6'h01;
         if (ph_q < 6'h1F) begin
            sclk <= ph_q[0];
            if (!ph_q[0]) begin
               rx_word <= {rx_word[14:0], dout};
            end else begin
               din <= sh_q[14];
               sh_q <= sh_q << 1;
            end
         end else if (ph_q == 6'h1F) begin
            sclk <= 1'h1;
         end else if (ph_q == (slow ? 6'h23 : 6'h20)) begin
            // Released data line must not keep its last level
            sync_n <= 1'h1;
            busy <= 1'h0;
            din <= ~din;
         end
      end
   end
endmodule // swfd_host_model

//--- sim/swfd_core_tb.sv
// Self-checking bench for the serial word decoder
`timescale 1ns/100ps
module swfd_core_tb;
   import swfd_pkg::*;
   logic ref_clk = 1'h0, reset = 1'h1, go = 1'h0, slow = 1'h0, resp_valid = 1'h0, ce = 1'h1;
   logic [15:0] tx = 16'h0000, rx_word;
   logic [2:0] resp_channel = 3'h0, dac_channel;
   logic [11:0] resp_data = 12'h000, dac_code;
   swfd_kind_t resp_kind = SWFD_KIND_ADC;
   logic sclk, sync_n, din, dout, busy, resp_ready, dac_load, soft_reset;
   int failures = 0, tests_run = 0, loads = 0, resets = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (dac_load === 1'h1) loads++;
      if (soft_reset === 1'h1) resets++;
   end
   swfd_core dut (.ref_clk(ref_clk), .ce(ce), .reset(reset), .sclk(sclk), .sync_n(sync_n),
      .din(din), .dout(dout), .resp_valid(resp_valid), .resp_kind(resp_kind),
      .resp_channel(resp_channel), .resp_data(resp_data), .resp_ready(resp_ready),
      .dac_load(dac_load), .dac_channel(dac_channel), .dac_code(dac_code),
      .soft_reset(soft_reset));
   swfd_host_model host (.ref_clk(ref_clk), .reset(reset), .go(go), .slow(slow), .tx_word(tx),
      .sclk(sclk), .sync_n(sync_n), .din(din), .dout(dout), .busy(busy), .rx_word(rx_word));
   // ==========================================================
   // Shared tasks
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic bail(int n, int lim);
      if (n >= lim) begin
         failures++;
         wrap_up();
      end
   endtask
   task automatic frame(logic [15:0] w);
      int n;
      @(posedge ref_clk);
      tx <= w;
      go <= 1'h1;
      @(posedge ref_clk);
      go <= 1'h0;
      @(posedge ref_clk);
      for (n = 0; n < 2000 && busy; n++) @(posedge ref_clk);
      bail(n, 2000);
      repeat (12) @(posedge ref_clk);
   endtask
   task automatic request(swfd_kind_t k, logic [2:0] ch, logic [11:0] d);
      int n;
      for (n = 0; n < 200 && resp_ready !== 1'h1; n++) @(negedge ref_clk);
      bail(n, 200);
      @(posedge ref_clk);
      resp_kind <= k;
      resp_channel <= ch;
      resp_data <= d;
      resp_valid <= 1'h1;
      @(posedge ref_clk);
      resp_valid <= 1'h0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_dac_write;
      for (int c = 0; c < 8; c++) begin
         frame({MSB_DAC, 3'(c), 12'hA50 + 12'(c)});
         check("dac_channel", 16'(c), 16'(dac_channel));
         check("dac_code", 16'hA50 + 16'(c), 16'(dac_code));
      end
      check("load_count", 16'h0008, 16'(loads));
   endtask
   task automatic t_readback;
      for (int c = 0; c < 8; c++) begin
         request(SWFD_KIND_DAC, 3'(c), 12'h0FF);
         frame(IDLE_WORD);
         check("readback", {1'h1, 3'(c), 12'hA50 + 12'(c)}, rx_word);
      end
   endtask
   task automatic t_adc_temp;
      slow <= 1'h1;
      request(SWFD_KIND_ADC, 3'h5, 12'h123);
      frame(IDLE_WORD);
      check("adc_word", {1'h0, 3'h5, 12'h123}, rx_word);
      request(SWFD_KIND_TEMP, 3'h2, 12'hFED);
      frame(IDLE_WORD);
      check("temp_word", {4'h8, 12'hFED}, rx_word);
      slow <= 1'h0;
   endtask
   task automatic t_soft_reset;
      frame(16'h7DAD);
      check("wrong_key", 16'h0000, 16'(resets));
      check("code_kept", 16'hA57, 16'(dac_code));
      frame({1'h0, RESET_ADDR, SOFTWARE_RESET_KEY});
      check("reset_count", 16'h0001, 16'(resets));
      check("code_clear", 16'h0000, 16'(dac_code));
      request(SWFD_KIND_DAC, 3'h3, 12'h0FF);
      frame(IDLE_WORD);
      check("store_clear", 16'hB000, rx_word);
   endtask
   // A word sent while the enable is low must leave all state frozen
   task automatic t_freeze;
      ce <= 1'h0;
      frame({MSB_DAC, 3'h6, 12'h3C3});
      check("frozen_code", 16'h0000, 16'(dac_code));
      check("frozen_loads", 16'h0008, 16'(loads));
      ce <= 1'h1;
      repeat (4) @(posedge ref_clk);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'h0;
      repeat (4) @(posedge ref_clk);
      t_dac_write();
      t_readback();
      t_adc_temp();
      t_soft_reset();
      t_freeze();
      wrap_up();
   end
endmodule // swfd_core_tb
